// *** swi_i2c_switch.sv ***
// I2C slave with status and control registers of a four-port switch
`default_nettype none
module swi_i2c_switch
   import swi_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       addr_sel,
   input  wire logic [3:0] cable_power_sense,
   input  wire logic [3:0] clock_valid,
   output logic            sda_out,
   output logic            sda_oe,
   output logic            irq,
   output logic [1:0]      active_port,
   output logic [3:0]      port_enable,
   output logic            low_power_state,
   output logic            standby_state,
   output logic            clk_detect_en,
   output logic [1:0]      edge_rate,
   output logic [1:0]      ovs_level
);
   logic [SWI_SYNC_W-1:0] sync_q;
   logic                  scl_s;
   logic                  sda_s;
   logic                  asel_s;
   logic [3:0]            pwr_s;
   logic [3:0]            cv_s;

   swi_sync #(.W(SWI_SYNC_W)) u_sync (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .d   ({scl_in, sda_in, addr_sel, cable_power_sense, clock_valid}),
      .q   (sync_q)
   );

   assign {scl_s, sda_s, asel_s, pwr_s, cv_s} = sync_q;

   swi_state_t  state_reg, state_next;
   logic        scl_reg, sda_reg;
   logic [3:0]  cnt_reg, cnt_next;
   logic [7:0]  shift_reg, shift_next;
   logic [3:0]  ptr_reg, ptr_next;
   logic        rw_reg, rw_next;
   logic        mack_reg, mack_next;
   logic        oe_reg, oe_next;
   logic        rdstat_reg, rdstat_next;
   swi_ctrl_t   ctrl_reg, ctrl_next;
   swi_pcfg_t   pcfg_reg, pcfg_next;
   logic [1:0]  sel_reg, sel_next;
   swi_status_t stat_prev_reg, stat_now;
   logic        irq_reg, irq_next;
   logic [3:0]  pen_reg;
   logic        rd_done;
   logic [7:0]  rd_byte;

   // Bus conditions seen on the synchronised lines
   wire       scl_rise = scl_s & ~scl_reg;
   wire       scl_fall = ~scl_s & scl_reg;
   wire       start_c  = scl_s & scl_reg & sda_reg & ~sda_s;
   wire       stop_c   = scl_s & scl_reg & ~sda_reg & sda_s;
   wire       byte_end = scl_fall && (cnt_reg == SWI_BYTE_BITS);
   wire [6:0] my_addr  = {SWI_ADDR_BASE[6:1], asel_s};
   wire       rx_state = (state_reg == SWI_ADDR) ||
                         (state_reg == SWI_SUB) ||
                         (state_reg == SWI_WDATA);

   // Automatic choice falls back to the priority port when none is powered
   wire [1:0] low_port = pwr_s[0] ? SWI_PORT1 :
                         pwr_s[1] ? SWI_PORT2 :
                         pwr_s[2] ? SWI_PORT3 :
                         pwr_s[3] ? SWI_PORT4 : ctrl_reg.prio;
   wire [1:0] auto_port = pwr_s[ctrl_reg.prio] ? ctrl_reg.prio
                                              : low_port;
   assign sel_next = ctrl_reg.auto_sel ? auto_port
                                       : pcfg_reg.man_port;

   // Status is rebuilt every cycle from live inputs, never latched
   always_comb begin
      stat_now.rsvd   = 1'b0;
      stat_now.port   = sel_reg;
      stat_now.clk_ok = pcfg_reg.clk_det_off | cv_s[sel_reg];
      stat_now.pwr    = pwr_s;
   end

   // Register read decode; unmapped offsets return zero
   always_comb begin
      if (ptr_reg == SWI_REG_STATUS) begin
         rd_byte = stat_now;
      end else if (ptr_reg == SWI_REG_CTRL) begin
         rd_byte = ctrl_reg;
      end else if (ptr_reg == SWI_REG_PCFG) begin
         rd_byte = pcfg_reg;
      end else begin
         rd_byte = SWI_RD_NONE;
      end
   end

   always_comb begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      shift_next  = shift_reg;
      ptr_next    = ptr_reg;
      rw_next     = rw_reg;
      mack_next   = mack_reg;
      oe_next     = oe_reg;
      rdstat_next = rdstat_reg;
      ctrl_next   = ctrl_reg;
      pcfg_next   = pcfg_reg;
      rd_done     = 1'b0;
      if (stop_c) begin
         state_next = SWI_IDLE;
         oe_next    = 1'b0;
      end else if (start_c) begin
         state_next = SWI_ADDR;
         cnt_next   = '0;
         oe_next    = 1'b0;
      end else begin
         if (rx_state && scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
         end
         case (state_reg)
            SWI_ADDR: begin
               if (byte_end) begin
                  if (shift_reg[7:1] == my_addr) begin
                     rw_next    = shift_reg[0];
                     oe_next    = 1'b1;
                     state_next = SWI_ADDR_ACK;
                  end else begin
                     state_next = SWI_IDLE;
                  end
               end
            end
            SWI_ADDR_ACK: begin
               if (scl_fall) begin
                  cnt_next = '0;
                  if (rw_reg) begin
                     shift_next  = rd_byte;
                     oe_next     = ~rd_byte[7];
                     rdstat_next = (ptr_reg == SWI_REG_STATUS);
                     state_next  = SWI_RDATA;
                  end else begin
                     oe_next    = 1'b0;
                     state_next = SWI_SUB;
                  end
               end
            end
            SWI_SUB: begin
               if (byte_end) begin
                  if (shift_reg[7:4] == SWI_SUB_HI) begin
                     ptr_next   = shift_reg[3:0];
                     oe_next    = 1'b1;
                     state_next = SWI_SUB_ACK;
                  end else begin
                     state_next = SWI_IDLE;
                  end
               end
            end
            SWI_SUB_ACK, SWI_WACK: begin
               if (scl_fall) begin
                  oe_next    = 1'b0;
                  cnt_next   = '0;
                  state_next = SWI_WDATA;
               end
            end
            SWI_WDATA: begin
               if (byte_end) begin
                  // Reserved bits are masked so they always read zero
                  if (ptr_reg == SWI_REG_CTRL) begin
                     ctrl_next = shift_reg & SWI_CTRL_WMASK;
                  end else if (ptr_reg == SWI_REG_PCFG) begin
                     pcfg_next = shift_reg & SWI_PCFG_WMASK;
                  end
                  oe_next    = 1'b1;
                  state_next = SWI_WACK;
               end
            end
            SWI_RDATA: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_reg == SWI_BYTE_BITS) begin
                     oe_next    = 1'b0;
                     rd_done    = rdstat_reg;
                     state_next = SWI_RACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = ~shift_reg[6];
                  end
               end
            end
            SWI_RACK: begin
               if (scl_rise) begin
                  mack_next = ~sda_s;
               end else if (scl_fall) begin
                  if (mack_reg) begin
                     shift_next  = rd_byte;
                     oe_next     = ~rd_byte[7];
                     cnt_next    = '0;
                     rdstat_next = (ptr_reg == SWI_REG_STATUS);
                     state_next  = SWI_RDATA;
                  end else begin
                     state_next = SWI_IDLE;
                  end
               end
            end
            default: begin
               state_next = state_reg;
            end
         endcase
      end
   end

   // A change in the same cycle as a finished status read keeps irq high
   assign irq_next = (stat_now != stat_prev_reg) |
                     (irq_reg & ~rd_done);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg  <= SWI_IDLE;
         scl_reg    <= 1'b1;
         sda_reg    <= 1'b1;
         cnt_reg    <= '0;
         shift_reg  <= '0;
         ptr_reg    <= '0;
         rw_reg     <= 1'b0;
         mack_reg   <= 1'b0;
         oe_reg     <= 1'b0;
         rdstat_reg <= 1'b0;
      end else if (ce) begin
         state_reg  <= state_next;
         scl_reg    <= scl_s;
         sda_reg    <= sda_s;
         cnt_reg    <= cnt_next;
         shift_reg  <= shift_next;
         ptr_reg    <= ptr_next;
         rw_reg     <= rw_next;
         mack_reg   <= mack_next;
         oe_reg     <= oe_next;
         rdstat_reg <= rdstat_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg      <= SWI_CTRL_RST;
         pcfg_reg      <= SWI_PCFG_RST;
         sel_reg       <= SWI_PORT1;
         pen_reg       <= '0;
         stat_prev_reg <= '0;
         irq_reg       <= 1'b0;
      end else if (ce) begin
         ctrl_reg      <= ctrl_next;
         pcfg_reg      <= pcfg_next;
         sel_reg       <= sel_next;
         pen_reg       <= 4'(1) << sel_next;
         stat_prev_reg <= stat_now;
         irq_reg       <= irq_next;
      end
   end

   // Open drain: the line is only ever pulled low
   assign sda_out         = 1'b0;
   assign sda_oe          = oe_reg;
   assign irq             = irq_reg;
   assign active_port     = sel_reg;
   assign port_enable     = pen_reg;
   assign low_power_state = ctrl_reg.pwr_mode[1];
   assign standby_state   = (ctrl_reg.pwr_mode == SWI_MODE_STBY);
   assign clk_detect_en   = ~pcfg_reg.clk_det_off;
   assign edge_rate       = ctrl_reg.edge_rate;
   assign ovs_level       = pcfg_reg.ovs;
endmodule
`default_nettype wire

// *** swi_pkg.sv ***
// Constants, register layouts and state codes of the port switch I2C block
// How it works
// - Start, address, write bit; device acks match
// - Subaddress byte, upper nibble zero, acknowledged
// - Pointer kept whether or not stop follows
// - Start, address, read bit; device sends byte
// - Master ack requests another byte
// - Master nack then stop; device releases line
// - Read byte is current addressed register content
// - Status bit7 zero, bits6:5 active port
// - Bit4 clock valid, one when detection off
// - Bits3:0 show cable power of ports 4..1
// - Status read-only, tracks conditions live
// - Interrupt high, low after status read
// - Control 7:6 normal, standby, low power
// - Bit5 picks automatic or manual selection
// - Bits4:3 name the priority port
// - Register 3 bit7 disables clock detection
`default_nettype none
package swi_pkg;
   localparam int          SWI_NPORT      = 4;
   localparam int          SWI_SYNC_W     = 3 + 2 * SWI_NPORT;
   localparam logic [6:0]  SWI_ADDR_BASE  = 7'h2c;
   localparam logic [3:0]  SWI_REG_STATUS = 4'h1;
   localparam logic [3:0]  SWI_REG_CTRL   = 4'h2;
   localparam logic [3:0]  SWI_REG_PCFG   = 4'h3;
   localparam logic [3:0]  SWI_SUB_HI     = 4'h0;
   localparam logic [3:0]  SWI_BYTE_BITS  = 4'h8;
   localparam logic [7:0]  SWI_CTRL_RST   = 8'h00;
   localparam logic [7:0]  SWI_PCFG_RST   = 8'h08;
   localparam logic [7:0]  SWI_CTRL_WMASK = 8'hfb;
   localparam logic [7:0]  SWI_PCFG_WMASK = 8'hf8;
   localparam logic [7:0]  SWI_RD_NONE    = 8'h00;
   localparam logic [1:0]  SWI_MODE_STBY  = 2'h1;
   localparam logic [1:0]  SWI_PORT1      = 2'h0;
   localparam logic [1:0]  SWI_PORT2      = 2'h1;
   localparam logic [1:0]  SWI_PORT3      = 2'h2;
   localparam logic [1:0]  SWI_PORT4      = 2'h3;

   typedef struct packed {
      logic       rsvd;
      logic [1:0] port;
      logic       clk_ok;
      logic [3:0] pwr;
   } swi_status_t;

   typedef struct packed {
      logic [1:0] pwr_mode;
      logic       auto_sel;
      logic [1:0] prio;
      logic       rsvd;
      logic [1:0] edge_rate;
   } swi_ctrl_t;

   typedef struct packed {
      logic       clk_det_off;
      logic [1:0] man_port;
      logic [1:0] ovs;
      logic [2:0] rsvd;
   } swi_pcfg_t;

   typedef enum logic [3:0] {
      SWI_IDLE, SWI_ADDR, SWI_ADDR_ACK, SWI_SUB, SWI_SUB_ACK,
      SWI_WDATA, SWI_WACK, SWI_RDATA, SWI_RACK
   } swi_state_t;
endpackage
`default_nettype wire

// *** swi_sync.sv ***
// Two-stage synchroniser for pin inputs
`default_nettype none
module swi_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else if (ce) begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// *** swi_i2c_switch_chk.sv ***
// Assertions on the pins of the port switch I2C block
`default_nettype none
module swi_i2c_switch_chk
   import swi_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic [3:0] cable_power_sense,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       irq,
   input wire logic [1:0] active_port,
   input wire logic [3:0] port_enable,
   input wire logic       low_power_state,
   input wire logic       standby_state
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_ONEHOT: assert property ($onehot0(port_enable))
      else $error("port enable not one-hot");
   AST_PEN: assert property ($changed(active_port) |-> ##[0:2]
      port_enable == (4'h1 << active_port)) else $error("enable lags port");
   AST_MODES: assert property (!(low_power_state && standby_state))
      else $error("two power modes at once");
   AST_OD: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   AST_SDA_LOW: assert property ($changed(sda_oe) |->
      !scl_in && !$past(scl_in)) else $error("data moved in clock high");
   AST_STOP: assert property (scl_in && $past(scl_in) && $rose(sda_in)
      |-> ##[1:6] !sda_oe) else $error("line held after stop");
   AST_IRQ_SET: assert property ($changed(cable_power_sense)
      |-> ##[1:6] irq) else $error("no interrupt on change");
   AST_IRQ_CLR: assert property ($fell(irq) |-> !scl_in && !sda_oe)
      else $error("interrupt dropped outside a read");
endmodule
bind swi_i2c_switch swi_i2c_switch_chk chk_u (.clk, .rst, .scl_in, .sda_in,
   .cable_power_sense, .sda_out, .sda_oe, .irq, .active_port, .port_enable,
   .low_power_state, .standby_state);
`default_nettype wire

// *** swi_mst.sv ***
// I2C master model standing in for the sink controller
`default_nettype none
module swi_mst (
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {scl, sda_low} = 2'b10;
   task automatic q(input int n);
      repeat (n) @(negedge clk);
   endtask
   // st=1 start or repeated start, st=0 stop: SDA moves while SCL is high
   task automatic cond(input logic st);
      q(2);
      sda_low = !st;
      q(8);
      scl = 1'b1;
      q(8);
      sda_low = st;
      q(8);
      scl = !st;
   endtask
   // Two cycles of hold after SCL falls, so SDA never moves with it
   task automatic bit_x(input logic b, output logic r);
      q(2);
      sda_low = !b;
      q(8);
      scl = 1'b1;
      q(8);
      r = sda;
      q(8);
      scl = 1'b0;
   endtask
   // On a read, last=0 acks to ask for more, last=1 ends the transfer
   task automatic byte_x(input logic [7:0] d, input logic last,
                         output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r[i]);
      bit_x(last, ack);
      ack = !ack;
   endtask
endmodule
`default_nettype wire

// *** switch_i2c_status_control_tb.sv ***
// Self-checking bench for the port switch I2C block
`default_nettype none
module switch_i2c_status_control_tb;
   import swi_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, ce, asel, scl, sda_low, sda_oe, irq, lp, sb, cde, a;
   logic [3:0] pwr, cv, pen;
   logic       so;
   logic [1:0] ap, er, ov;
   logic [7:0] v, w;
   int         err_total = 0;
   int         compares = 0;
   wire  logic       sda = !(sda_oe || sda_low);
   wire  logic [6:0] adr = SWI_ADDR_BASE | {6'h0, asel};
   initial begin
      clk = 1'b0;
      forever #2 clk = !clk;
   end
   swi_i2c_switch dut_u (.clk, .rst, .ce, .scl_in(scl), .sda_in(sda),
      .addr_sel(asel), .cable_power_sense(pwr), .clock_valid(cv),
      .sda_out(so), .sda_oe, .irq, .active_port(ap), .port_enable(pen),
      .low_power_state(lp), .standby_state(sb), .clk_detect_en(cde),
      .edge_rate(er), .ovs_level(ov));
   swi_mst m_u (.clk, .sda, .scl, .sda_low);
   task automatic chk(input logic ok, input string s);
      compares++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, s);
      end
   endtask
   task automatic conclude();
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic ptr(input logic [3:0] r, input logic p);
      logic a0;
      m_u.cond(1'b1);
      m_u.byte_x({adr, 1'b0}, 1'b1, w, a0);
      m_u.byte_x({SWI_SUB_HI, r}, 1'b1, w, a);
      chk({a0, a} === 2'h3, "pointer not acked");
      if (p)
         m_u.cond(1'b0);
   endtask
   task automatic rd(input logic [3:0] r, input logic p, input logic [7:0] e);
      ptr(r, p);
      m_u.cond(1'b1);
      m_u.byte_x({adr, 1'b1}, 1'b1, w, a);
      chk(a === 1'b1, "read not acked");
      m_u.byte_x(8'hff, 1'b1, v, a);
      m_u.cond(1'b0);
      chk(v === e, "read value");
   endtask
   task automatic wr(input logic [3:0] r, input logic [7:0] d);
      ptr(r, 1'b0);
      m_u.byte_x(d, 1'b1, w, a);
      m_u.cond(1'b0);
      chk(a === 1'b1, "data not acked");
   endtask
   task automatic t_reset();
      chk({sda_oe, irq, ap, pen, lp, sb, cde} === 11'h009, "reset");
      rd(SWI_REG_CTRL, 1'b1, 8'h00);
      rd(SWI_REG_PCFG, 1'b1, 8'h08);
      rd(SWI_REG_STATUS, 1'b1, 8'h00);
   endtask
   task automatic t_status();
      pwr = 4'b1010;
      cv = 4'b1011;
      m_u.q(8);
      chk(irq === 1'b1, "no interrupt");
      ptr(SWI_REG_STATUS, 1'b1);
      m_u.cond(1'b1);
      m_u.byte_x({adr, 1'b1}, 1'b1, v, a);
      m_u.byte_x(8'hff, 1'b0, v, a);
      chk(irq === 1'b0, "interrupt kept");
      m_u.byte_x(8'hff, 1'b1, w, a);
      m_u.cond(1'b0);
      chk(v === 8'h1a && w === 8'h1a, "status bytes");
      cv = 4'b0000;
      m_u.q(8);
      rd(SWI_REG_STATUS, 1'b0, 8'h0a);
      wr(SWI_REG_STATUS, 8'hff);
      rd(SWI_REG_STATUS, 1'b1, 8'h0a);
   endtask
   task automatic t_manual();
      cv = 4'b1011;
      wr(SWI_REG_PCFG, 8'hc8);
      chk({ap, pen, cde} === 7'h48, "manual port");
      chk(ov === 2'h1 && so === 1'b0, "ovs level or data pin");
      rd(SWI_REG_PCFG, 1'b1, 8'hc8);
      rd(SWI_REG_STATUS, 1'b1, 8'h5a);
      wr(SWI_REG_PCFG, 8'h58);
      chk(ov === 2'h3 && cde === 1'b1, "ovs level");
      rd(SWI_REG_STATUS, 1'b1, 8'h4a);
   endtask
   task automatic t_auto();
      wr(SWI_REG_CTRL, 8'h38);
      chk(ap === SWI_PORT4, "priority port");
      rd(SWI_REG_STATUS, 1'b1, 8'h7a);
      pwr = 4'b0110;
      m_u.q(8);
      chk(ap === SWI_PORT2, "lowest powered");
      rd(SWI_REG_CTRL, 1'b1, 8'h38);
      wr(SWI_REG_CTRL, 8'h00);
      chk(ap === SWI_PORT3, "manual again");
   endtask
   task automatic t_power();
      for (int i = 0; i < 4; i++) begin
         // Edge rate bits ride along so that output is exercised too
         wr(SWI_REG_CTRL, 8'((i << 6) | i));
         chk(lp === i[1] && sb === (i == 1) && er === i[1:0],
             "power mode");
      end
   endtask
   task automatic t_addr();
      asel = 1'b1;
      m_u.q(8);
      m_u.cond(1'b1);
      m_u.byte_x({SWI_ADDR_BASE, 1'b0}, 1'b1, w, a);
      m_u.cond(1'b0);
      chk(a === 1'b0, "foreign address acked");
      m_u.cond(1'b1);
      m_u.byte_x({adr, 1'b0}, 1'b1, w, a);
      m_u.byte_x(8'h13, 1'b1, w, a);
      m_u.cond(1'b0);
      chk(a === 1'b0, "bad subaddress acked");
      rd(SWI_REG_CTRL, 1'b1, 8'hc3);
   endtask
   // Clock enable low must freeze the synchronisers and the interrupt
   task automatic t_ce();
      rd(SWI_REG_STATUS, 1'b1, 8'h46);
      ce = 1'b0;
      cv = 4'b1111;
      m_u.q(8);
      chk({irq, ap} === 3'h2, "state moved while frozen");
      ce = 1'b1;
      m_u.q(8);
      chk(irq === 1'b1, "no interrupt after freeze");
      rd(SWI_REG_STATUS, 1'b1, 8'h56);
   endtask
   initial begin
      {rst, ce, asel, pwr, cv} = 11'h600;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      m_u.q(4);
      t_reset();
      t_status();
      t_manual();
      t_auto();
      t_power();
      t_addr();
      t_ce();
      conclude();
   end
   // Bound on the whole run so a hang still reaches the verdict
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule
`default_nettype wire
